// ### pkg/mct32_params.svh
// Contract
// - Four instances, each with 32-bit counter
// - Count internal clock or external clock input
// - Timer mode and counter mode supported
// - 32-bit prescaler divides the count source
// - Four 32-bit match registers compared continuously
// - Continuous match action keeps counter running
// - Stop match action halts the counter
// - Reset match action zeroes counter, continues
// - Two capture channels latch count on transition
// - Capture event raises interrupt when enabled
// - Four outputs: low, high, toggle, nothing
// - Two match registers issue timed DMA requests
`ifndef MCT32_PARAMS_SVH
`define MCT32_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MCT32_ADDR_CTRL 12'h000
`define MCT32_ADDR_COUNT 12'h004
`define MCT32_ADDR_PRESCALE 12'h008
`define MCT32_ADDR_PCOUNT 12'h00c
`define MCT32_ADDR_MATCH_CTRL 12'h010
`define MCT32_ADDR_CAP_CTRL 12'h014
`define MCT32_ADDR_OUT_CTRL 12'h018
`define MCT32_ADDR_OUT_STATE 12'h01c
`define MCT32_ADDR_INT_STATUS 12'h020
`define MCT32_ADDR_INT_MASK 12'h024
`define MCT32_ADDR_MATCH0 12'h030
`define MCT32_ADDR_CAPTURE0 12'h040

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MCT32_CTRL_ENABLE 0
`define MCT32_CTRL_RESET 1
`define MCT32_CTRL_MODE 2
`define MCT32_CTRL_EDGE_LO 3
`define MCT32_CTRL_EDGE_HI 4

// Match control: per channel, bit 3c+0 interrupt, 3c+1 reset, 3c+2 stop.
`define MCT32_MC_INT 0
`define MCT32_MC_RST 1
`define MCT32_MC_STOP 2
// Capture control: per channel, bit 3c+0 rise, 3c+1 fall, 3c+2 interrupt.
`define MCT32_CC_RISE 0
`define MCT32_CC_FALL 1
`define MCT32_CC_INT 2
// Output control: two bits per output, DMA enables at bits 8 and 9.
`define MCT32_OC_DMA 8
// Status layout: bits 0..3 match, bits 4..5 capture.
`define MCT32_ST_CAP 4

`define MCT32_RESET_WORD 32'h0000_0000

`endif

// ### pkg/mct32_pkg.sv
package mct32_pkg;
    typedef enum logic [1:0] {
        MCT32_OUT_NONE = 2'h0,
        MCT32_OUT_LOW = 2'h1,
        MCT32_OUT_HIGH = 2'h2,
        MCT32_OUT_TOGGLE = 2'h3
    } mct32_out_act_t;

    typedef enum logic [1:0] {
        MCT32_EDGE_RISE = 2'h0,
        MCT32_EDGE_FALL = 2'h1,
        MCT32_EDGE_BOTH = 2'h2
    } mct32_edge_t;

    typedef enum logic [2:0] {
        MCT32_APB_IDLE = 3'b001,
        MCT32_APB_SETUP = 3'b010,
        MCT32_APB_ACCESS = 3'b100
    } mct32_apb_st_t;
endpackage : mct32_pkg

// ### logic/mct32_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Two-flop synchroniser with rise and fall detection on the second stage.
// ----------------------------------------------------------------------------
module mct32_edge_sync #(
    parameter int WIDTH = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule : mct32_edge_sync
`default_nettype wire

// ### logic/mct32_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "mct32_params.svh"
// ----------------------------------------------------------------------------
// 32-bit timer/counter with prescaler, four match and two capture channels.
// One instance is one timer; the chip places four of these side by side.
// ----------------------------------------------------------------------------
module mct32_timer
    import mct32_pkg::*;
#(
    parameter int NUM_MATCH = 4,
    parameter int NUM_CAP = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clk,
    input wire logic [1:0] cap_in,
    output logic [3:0] match_out,
    output logic [1:0] dma_req,
    output logic irq
);
    if (NUM_MATCH != 4 || NUM_CAP != 2) begin : g_bad_cfg
        $error("mct32_timer supports four match and two capture channels only");
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [4:0] ctrl_q;
    logic [31:0] count_q;
    logic [31:0] prescale_q;
    logic [31:0] pcount_q;
    logic [11:0] mctrl_q;
    logic [5:0] cctrl_q;
    logic [9:0] octrl_q;
    logic [3:0] out_q;
    logic [5:0] status_q;
    logic [5:0] mask_q;
    logic [31:0] match_q [4];
    logic [31:0] cap_q [2];
    logic [1:0] dma_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    logic [2:0] in_rise;
    logic [2:0] in_fall;

    mct32_edge_sync #(.WIDTH(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({ext_clk, cap_in}),
        .rise(in_rise),
        .fall(in_fall)
    );

    // ------------------------------------------------------------------------
    // Count source and prescaler
    // ------------------------------------------------------------------------
    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            MCT32_EDGE_RISE: edge_pick = r;
            MCT32_EDGE_FALL: edge_pick = f;
            default: edge_pick = r | f;
        endcase
    endfunction : edge_pick

    wire counter_mode = ctrl_q[`MCT32_CTRL_MODE];
    wire [1:0] ext_edge_sel = ctrl_q[`MCT32_CTRL_EDGE_HI:`MCT32_CTRL_EDGE_LO];
    wire ext_tick = edge_pick(ext_edge_sel, in_rise[2], in_fall[2]);
    wire run = ctrl_q[`MCT32_CTRL_ENABLE] & ~ctrl_q[`MCT32_CTRL_RESET];
    wire src_tick = run & (counter_mode ? ext_tick : 1'b1);
    wire pre_wrap = src_tick & (pcount_q == prescale_q);
    wire cnt_tick = pre_wrap;

    // ------------------------------------------------------------------------
    // Match logic
    // ------------------------------------------------------------------------
    logic [3:0] hit;
    logic [3:0] hit_rst;
    logic [3:0] hit_stop;
    genvar gm;
    generate
        for (gm = 0; gm < 4; gm++) begin : g_match
            assign hit[gm] = cnt_tick & (count_q == match_q[gm]);
            assign hit_rst[gm] = hit[gm] & mctrl_q[3*gm+`MCT32_MC_RST];
            assign hit_stop[gm] = hit[gm] & mctrl_q[3*gm+`MCT32_MC_STOP];
        end
    endgenerate
    wire any_rst = |hit_rst;
    wire any_stop = |hit_stop;
    logic [3:0] mint_ev;
    assign mint_ev = hit & {mctrl_q[9], mctrl_q[6], mctrl_q[3], mctrl_q[0]};

    // ------------------------------------------------------------------------
    // Capture logic
    // ------------------------------------------------------------------------
    logic [1:0] cap_ev;
    logic [1:0] cint_ev;
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_cap
            assign cap_ev[gc] = (in_rise[gc] & cctrl_q[3*gc+`MCT32_CC_RISE])
                | (in_fall[gc] & cctrl_q[3*gc+`MCT32_CC_FALL]);
            assign cint_ev[gc] = cap_ev[gc] & cctrl_q[3*gc+`MCT32_CC_INT];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire acc = psel & penable & pready_q;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire sel_ctrl = (paddr == `MCT32_ADDR_CTRL);
    wire sel_count = (paddr == `MCT32_ADDR_COUNT);
    wire sel_pre = (paddr == `MCT32_ADDR_PRESCALE);
    wire sel_pcnt = (paddr == `MCT32_ADDR_PCOUNT);
    wire sel_mc = (paddr == `MCT32_ADDR_MATCH_CTRL);
    wire sel_cc = (paddr == `MCT32_ADDR_CAP_CTRL);
    wire sel_oc = (paddr == `MCT32_ADDR_OUT_CTRL);
    wire sel_os = (paddr == `MCT32_ADDR_OUT_STATE);
    wire sel_st = (paddr == `MCT32_ADDR_INT_STATUS);
    wire sel_mk = (paddr == `MCT32_ADDR_INT_MASK);
    wire sel_mr = (paddr[11:4] == 8'(`MCT32_ADDR_MATCH0 >> 4)) & (paddr[1:0] == 2'h0);
    wire sel_cr = (paddr[11:3] == 9'(`MCT32_ADDR_CAPTURE0 >> 3)) & (paddr[1:0] == 2'h0);
    wire mapped = sel_ctrl | sel_count | sel_pre | sel_pcnt | sel_mc | sel_cc | sel_oc
        | sel_os | sel_st | sel_mk | sel_mr | sel_cr;
    wire [1:0] midx = paddr[3:2];
    wire cidx = paddr[2];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `MCT32_RESET_WORD;
        if (sel_ctrl) begin
            rd_mux = {27'h0, ctrl_q};
        end else if (sel_count) begin
            rd_mux = count_q;
        end else if (sel_pre) begin
            rd_mux = prescale_q;
        end else if (sel_pcnt) begin
            rd_mux = pcount_q;
        end else if (sel_mc) begin
            rd_mux = {20'h0, mctrl_q};
        end else if (sel_cc) begin
            rd_mux = {26'h0, cctrl_q};
        end else if (sel_oc) begin
            rd_mux = {22'h0, octrl_q};
        end else if (sel_os) begin
            rd_mux = {28'h0, out_q};
        end else if (sel_st) begin
            rd_mux = {26'h0, status_q};
        end else if (sel_mk) begin
            rd_mux = {26'h0, mask_q};
        end else if (sel_mr) begin
            rd_mux = match_q[midx];
        end else if (sel_cr) begin
            rd_mux = cap_q[cidx];
        end
    end

    // One wait state: pready rises at the edge that ends the first access cycle, answer at the next edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= `MCT32_RESET_WORD;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : `MCT32_RESET_WORD;
        end
    end

    // ------------------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 5'h0;
            prescale_q <= `MCT32_RESET_WORD;
            mctrl_q <= 12'h0;
            cctrl_q <= 6'h0;
            octrl_q <= 10'h0;
            mask_q <= 6'h0;
            match_q <= '{default: 32'h0};
        end else begin
            if (wr & sel_ctrl) begin
                ctrl_q <= pwdata[4:0];
            end else if (any_stop) begin
                ctrl_q[`MCT32_CTRL_ENABLE] <= 1'b0;
            end
            if (wr & sel_pre) prescale_q <= pwdata;
            if (wr & sel_mc) mctrl_q <= pwdata[11:0];
            if (wr & sel_cc) cctrl_q <= pwdata[5:0];
            if (wr & sel_oc) octrl_q <= pwdata[9:0];
            if (wr & sel_mk) mask_q <= pwdata[5:0];
            if (wr & sel_mr) match_q[midx] <= pwdata;
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and main counter
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcount_q <= `MCT32_RESET_WORD;
            count_q <= `MCT32_RESET_WORD;
        end else if (ctrl_q[`MCT32_CTRL_RESET]) begin
            pcount_q <= `MCT32_RESET_WORD;
            count_q <= `MCT32_RESET_WORD;
        end else if (wr & sel_count) begin
            count_q <= pwdata;
            pcount_q <= `MCT32_RESET_WORD;
        end else begin
            if (pre_wrap) begin
                pcount_q <= `MCT32_RESET_WORD;
            end else if (src_tick) begin
                pcount_q <= pcount_q + 32'h1;
            end
            if (any_rst) begin
                count_q <= `MCT32_RESET_WORD;
            end else if (cnt_tick) begin
                count_q <= count_q + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Captures, outputs, DMA and interrupt
    // ------------------------------------------------------------------------
    function automatic logic out_next(input logic [1:0] act, input logic cur);
        case (act)
            MCT32_OUT_LOW: out_next = 1'b0;
            MCT32_OUT_HIGH: out_next = 1'b1;
            MCT32_OUT_TOGGLE: out_next = ~cur;
            default: out_next = cur;
        endcase
    endfunction : out_next

    logic [3:0] out_d;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            out_d[i] = hit[i] ? out_next(octrl_q[2*i +: 2], out_q[i]) : out_q[i];
        end
    end

    // A status read clears the flags it returned; a new event in that cycle survives.
    wire [5:0] st_set = {cint_ev, mint_ev};
    wire [5:0] st_clr = (rd & sel_st) ? prdata_q[5:0] : 6'h0;
    wire [5:0] status_d = (status_q & ~st_clr) | st_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= '{default: 32'h0};
            out_q <= 4'h0;
            dma_q <= 2'h0;
            status_q <= 6'h0;
            irq_q <= 1'b0;
        end else begin
            if (cap_ev[0]) cap_q[0] <= count_q;
            if (cap_ev[1]) cap_q[1] <= count_q;
            out_q <= (wr & sel_os) ? pwdata[3:0] : out_d;
            dma_q <= hit[1:0] & octrl_q[`MCT32_OC_DMA +: 2];
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign match_out = out_q;
    assign dma_req = dma_q;
    assign irq = irq_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_prescale_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (src_tick && pcount_q == prescale_q && !ctrl_q[1] && !(wr && sel_count))
        |=> pcount_q == 32'h0)
        else $error("prescale counter did not wrap");
    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_tick && !any_rst && !ctrl_q[1] && !(wr && sel_count))
        |=> count_q == $past(count_q) + 32'h1)
        else $error("counter did not advance on prescale wrap");
    chk_timer_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (run && !counter_mode && !(wr && sel_count))
        |=> pcount_q == (($past(pcount_q) == $past(prescale_q)) ? 32'h0 : $past(pcount_q) + 32'h1))
        else $error("timer mode missed a clock");
    chk_counter_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (counter_mode && !ext_tick && !ctrl_q[1] && !(wr && sel_count))
        |=> $stable(pcount_q) && $stable(count_q))
        else $error("counter mode counted without an external edge");
    chk_match_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (any_rst && !ctrl_q[1] && !(wr && sel_count)) |=> count_q == 32'h0)
        else $error("reset on match did not zero the counter");
    chk_match_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (any_stop && !(wr && sel_ctrl)) |=> !ctrl_q[0])
        else $error("stop on match did not halt");
    chk_match_cont: assert property (@(posedge pclk) disable iff (!presetn)
        (hit[0] && !any_stop && !any_rst && !(wr && sel_ctrl)) |=> ctrl_q[0])
        else $error("continuous match disturbed the counter");
    chk_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        mint_ev[0] |=> status_q[0])
        else $error("match interrupt flag not set");
    chk_capture_val: assert property (@(posedge pclk) disable iff (!presetn)
        cap_ev[1] |=> cap_q[1] == $past(count_q))
        else $error("capture did not latch the count");
    chk_capture_int: assert property (@(posedge pclk) disable iff (!presetn)
        cint_ev[0] |=> status_q[`MCT32_ST_CAP])
        else $error("capture interrupt flag not set");
    chk_out_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        (hit[0] && octrl_q[1:0] == 2'h3 && !(wr && sel_os)) |=> match_out[0] != $past(match_out[0]))
        else $error("match output did not toggle");
    chk_dma_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (hit[0] && octrl_q[`MCT32_OC_DMA]) |=> dma_req[0] ##1 (!dma_req[0] || $past(hit[0])))
        else $error("dma request not a one-cycle pulse");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |($past(status_d) & $past(mask_q)))
        else $error("interrupt output does not follow masked flags");
    chk_count_width: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_tick && count_q == 32'hffff_ffff && !any_rst && !ctrl_q[1] && !(wr && sel_count))
        |=> count_q == 32'h0)
        else $error("32-bit counter did not roll over");
endmodule : mct32_timer
`default_nettype wire

// ### test/mct32_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "mct32_params.svh"
module mct32_timer_tb_top
    import mct32_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk, irq, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, w;
    logic [1:0] cap_in, dma_req;
    logic [3:0] match_out;
    int bad_count, n_compared;
    int dma0_n = 0;
    int dma1_n = 0;

    mct32_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk(ext_clk), .cap_in(cap_in), .match_out(match_out), .dma_req(dma_req), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (dma_req[0] === 1'b1) dma0_n++;
        if (dma_req[1] === 1'b1) dma1_n++;
    end

    // ------------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // The master waits for pready however long it takes; only the watchdog ends a hang.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
        chk({31'h0, last_err}, 32'h0, "write error response");
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] got;
        xfer(1'b0, a, 32'h0, got);
        chk(got, exp, what);
    endtask : rdc

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1, "irq rise");
    endtask : wait_irq

    task automatic ext_pulses(input int k);
        repeat (k) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask : ext_pulses

    task automatic final_report;
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        final_report();
    end

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_clk = 1'b0;
        cap_in = 2'h0;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({27'h0, match_out, irq}, 32'h0, "outputs after reset");
        rdc(`MCT32_ADDR_CTRL, 32'h0, "ctrl reset");
        rdc(`MCT32_ADDR_COUNT, 32'h0, "count reset");
        rdc(`MCT32_ADDR_MATCH0, 32'h0, "match0 reset");
        rdc(`MCT32_ADDR_INT_STATUS, 32'h0, "status reset");
        wr(`MCT32_ADDR_CTRL, 32'hffff_ffe0);
        rdc(`MCT32_ADDR_CTRL, 32'h0, "ctrl reserved bits");
        wr(`MCT32_ADDR_PCOUNT, 32'h55);
        rdc(`MCT32_ADDR_PCOUNT, 32'h0, "pcount read only");
        xfer(1'b0, 12'h02c, 32'h0, v);
        chk(v, 32'h0, "unmapped read data");
        chk({31'h0, last_err}, 32'h1, "unmapped error response");
        // Reset on match0 with toggle, high, low and hold actions on the four outputs.
        wr(`MCT32_ADDR_OUT_STATE, 32'hc);
        wr(`MCT32_ADDR_OUT_CTRL, {22'h0, 2'h3, MCT32_OUT_NONE, MCT32_OUT_LOW, MCT32_OUT_HIGH, MCT32_OUT_TOGGLE});
        wr(`MCT32_ADDR_MATCH0, 32'd9);
        wr(`MCT32_ADDR_MATCH0 + 12'h4, 32'd4);
        wr(`MCT32_ADDR_MATCH0 + 12'h8, 32'd6);
        wr(`MCT32_ADDR_MATCH0 + 12'hc, 32'd7);
        wr(`MCT32_ADDR_MATCH_CTRL, 32'h3);
        wr(`MCT32_ADDR_INT_MASK, 32'h1);
        wr(`MCT32_ADDR_CTRL, 32'h1);
        wait_irq(40);
        chk({28'h0, match_out}, 32'hb, "match outputs");
        repeat (40) @(posedge pclk);
        xfer(1'b0, `MCT32_ADDR_COUNT, 32'h0, v);
        chk({31'h0, v <= 32'd9}, 32'h1, "count wraps at match");
        chk({31'h0, dma0_n > 0 && dma1_n > 0}, 32'h1, "dma pulses");
        xfer(1'b0, `MCT32_ADDR_INT_STATUS, 32'h0, v);
        chk(v & 32'h1, 32'h1, "match0 flag");
        wr(`MCT32_ADDR_INT_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`MCT32_ADDR_CTRL, 32'h0);
        xfer(1'b0, `MCT32_ADDR_INT_STATUS, 32'h0, v);
        rdc(`MCT32_ADDR_INT_STATUS, 32'h0, "status cleared by read");
        // Match2 only flags while the count runs on, match3 then halts it.
        wr(`MCT32_ADDR_MATCH0 + 12'h8, 32'd10);
        wr(`MCT32_ADDR_MATCH0 + 12'hc, 32'd20);
        wr(`MCT32_ADDR_MATCH_CTRL, 32'ha40);
        wr(`MCT32_ADDR_INT_MASK, 32'h4);
        wr(`MCT32_ADDR_COUNT, 32'h0);
        wr(`MCT32_ADDR_CTRL, 32'h1);
        wait_irq(60);
        wr(`MCT32_ADDR_INT_MASK, 32'h8);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq follows new mask");
        wait_irq(60);
        repeat (4) @(posedge pclk);
        xfer(1'b0, `MCT32_ADDR_COUNT, 32'h0, v);
        xfer(1'b0, `MCT32_ADDR_COUNT, 32'h0, w);
        chk(w, v, "count halted");
        chk({31'h0, v >= 32'd20 && v <= 32'd21}, 32'h1, "count ran past match2");
        rdc(`MCT32_ADDR_CTRL, 32'h0, "stop clears enable");
        // Captures with the count frozen, so the latched value is exact.
        xfer(1'b0, `MCT32_ADDR_INT_STATUS, 32'h0, v);
        wr(`MCT32_ADDR_COUNT, 32'h1234_5678);
        wr(`MCT32_ADDR_CAP_CTRL, 32'h35);
        wr(`MCT32_ADDR_INT_MASK, 32'h30);
        cap_in <= 2'h3;
        repeat (6) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "capture irq");
        rdc(`MCT32_ADDR_CAPTURE0, 32'h1234_5678, "capture0 on rise");
        rdc(`MCT32_ADDR_INT_STATUS, 32'h10, "capture0 flag only");
        wr(`MCT32_ADDR_COUNT, 32'ha5);
        cap_in <= 2'h0;
        repeat (6) @(posedge pclk);
        rdc(`MCT32_ADDR_CAPTURE0 + 12'h4, 32'ha5, "capture1 on fall");
        rdc(`MCT32_ADDR_INT_STATUS, 32'h20, "capture1 flag");
        // External clock in counter mode, each edge selection.
        for (int e = 0; e < 3; e++) begin
            wr(`MCT32_ADDR_COUNT, 32'h0);
            wr(`MCT32_ADDR_CTRL, 32'h5 | (e << 3));
            ext_pulses(6);
            wr(`MCT32_ADDR_CTRL, 32'h0);
            rdc(`MCT32_ADDR_COUNT, (e == 2) ? 32'd12 : 32'd6, "external count");
        end
        wr(`MCT32_ADDR_PRESCALE, 32'd2);
        wr(`MCT32_ADDR_COUNT, 32'h0);
        wr(`MCT32_ADDR_CTRL, 32'h5);
        ext_pulses(10);
        wr(`MCT32_ADDR_CTRL, 32'h0);
        rdc(`MCT32_ADDR_COUNT, 32'd3, "prescaled count");
        rdc(`MCT32_ADDR_PCOUNT, 32'd1, "prescale residue");
        final_report();
    end
endmodule : mct32_timer_tb_top
`default_nettype wire
